// [src/urt_top.sv]
`timescale 1ns/100ps
// ==========================================================
// Receive FIFO
module urt_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_ce,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_r;
  logic [AW:0]  rptr_r;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty
  assign o_valid = (wptr_r != rptr_r);
  assign o_ready = (wptr_r[AW-1:0] != rptr_r[AW-1:0]) || (wptr_r[AW] == rptr_r[AW]);
  assign push    = i_ce && i_valid && o_ready;
  assign pop     = i_ce && o_valid && i_ready;
  assign o_data  = mem[rptr_r[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wptr_r[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop)
      begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule // urt_fifo

`timescale 1ns/100ps
// ==========================================================
// Serial port with reload timer baud source
module urt_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  input  wire logic                 i_ext_clk,
  input  wire logic                 i_ext_int,
  input  wire logic                 i_rxd,
  output logic                      o_txd,
  input  wire logic                 i_mode3,
  input  wire logic                 i_rx_en,
  input  wire logic                 i_wr_stb,
  input  wire urt_pkg::urt_word_t   i_wr_word,
  input  wire logic                 i_rd_stb,
  output urt_pkg::urt_word_t        o_rd_word,
  output logic                      o_tx_done,
  output logic                      o_rx_done,
  input  wire logic                 i_clr_tx_done,
  input  wire logic                 i_clr_rx_done,
  input  wire logic                 i_ser_int_en,
  output logic                      o_ser_irq,
  input  wire urt_pkg::urt_tmr_cfg_t i_tmr_cfg,
  input  wire logic                 i_tl_wr,
  input  wire logic                 i_th_wr,
  input  wire logic [7:0]           i_tmr_wdata,
  output logic [7:0]                o_tl,
  output logic [7:0]                o_th,
  output logic                      o_tmr_ovf,
  input  wire logic                 i_clr_tmr_ovf,
  input  wire logic                 i_tmr_int_en,
  output logic                      o_tmr_irq
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] rxd_s_r;
  logic [1:0] eclk_s_r;
  logic [1:0] eint_s_r;
  logic       rxd_d_r;
  logic       eclk_d_r;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rxd_s_r  <= 2'h3;
      eclk_s_r <= 2'h0;
      eint_s_r <= 2'h0;
      rxd_d_r  <= 1'b1;
      eclk_d_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rxd_s_r  <= {rxd_s_r[0], i_rxd};
      eclk_s_r <= {eclk_s_r[0], i_ext_clk};
      eint_s_r <= {eint_s_r[0], i_ext_int};
      rxd_d_r  <= rxd_s_r[1];
      eclk_d_r <= eclk_s_r[1];
    end
  end

  // ==========================================================
  // Timer clock selection
  logic [5:0] presc_r;
  logic [5:0] presc_last;
  logic [2:0] ext_cnt_r;
  logic       div_tick;
  logic       ext_tick;
  logic       tmr_tick;
  logic       cnt_en;

  always_comb
  begin
    case (i_tmr_cfg.prescale)
      urt_pkg::PS_DIV12: presc_last = urt_pkg::DIV12_LAST; // RULE_09
      urt_pkg::PS_DIV48: presc_last = urt_pkg::DIV48_LAST; // RULE_09
      default:           presc_last = urt_pkg::DIV4_LAST;
    endcase
  end

  assign div_tick = (presc_r >= presc_last);
  assign ext_tick = eclk_s_r[1] && !eclk_d_r && (ext_cnt_r == urt_pkg::EXT8_LAST);
  assign tmr_tick = i_tmr_cfg.clk_sel ? 1'b1 : // RULE_09
                    (i_tmr_cfg.prescale == urt_pkg::PS_EXT8) ? ext_tick : div_tick;
  // Gate lets the external input hold off counting
  assign cnt_en = i_tmr_cfg.run && // RULE_14
                  (!i_tmr_cfg.gate || (eint_s_r[1] == i_tmr_cfg.int_pol));

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      presc_r   <= '0;
      ext_cnt_r <= '0;
    end
    else if (i_ce)
    begin
      presc_r <= div_tick ? 6'h00 : presc_r + 6'h01;
      if (eclk_s_r[1] && !eclk_d_r)
      begin
        ext_cnt_r <= ext_cnt_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // Baud timer: low count byte; high byte counts in modes 0 and 1 and is the reload in mode 2
  logic [7:0] tl_r;
  logic [7:0] th_r;
  logic [7:0] tl_nxt;
  logic [7:0] th_nxt;
  logic       ovf_cond;
  logic       ovf_pulse;
  logic       tmr_ovf_r;

  always_comb
  begin
    tl_nxt   = tl_r + 8'h01;
    th_nxt   = th_r;
    ovf_cond = 1'b0;
    case (i_tmr_cfg.mode)
      urt_pkg::TM_13:
      begin
        tl_nxt = {3'h0, tl_r[4:0] + 5'h01};
        if (tl_r[4:0] == urt_pkg::LOW5_ONES)
        begin
          th_nxt   = th_r + 8'h01;
          ovf_cond = (th_r == urt_pkg::BYTE_ONES);
        end
      end
      urt_pkg::TM_16:
      begin
        if (tl_r == urt_pkg::BYTE_ONES)
        begin
          th_nxt   = th_r + 8'h01; // RULE_10
          ovf_cond = (th_r == urt_pkg::BYTE_ONES); // RULE_10
        end
      end
      urt_pkg::TM_RELOAD:
      begin
        if (tl_r == urt_pkg::BYTE_ONES)
        begin
          tl_nxt   = th_r; // RULE_11
          ovf_cond = 1'b1; // RULE_11
        end
      end
      default:
      begin
        // Mode 3 halts this timer
        tl_nxt = tl_r;
      end
    endcase
  end

  assign ovf_pulse = i_ce && tmr_tick && cnt_en && ovf_cond; // RULE_15

  // Software writes win over the count in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tl_r <= urt_pkg::TL_RESET;
      th_r <= urt_pkg::TH_RESET;
    end
    else if (i_ce)
    begin
      if (i_tl_wr)
      begin
        tl_r <= i_tmr_wdata;
      end
      else if (tmr_tick && cnt_en)
      begin
        tl_r <= tl_nxt;
      end
      if (i_th_wr)
      begin
        th_r <= i_tmr_wdata;
      end
      else if (tmr_tick && cnt_en)
      begin
        th_r <= th_nxt; // RULE_12
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tmr_ovf_r <= 1'b0;
    end
    else if (ovf_pulse)
    begin
      tmr_ovf_r <= 1'b1; // RULE_11
    end
    else if (i_ce && i_clr_tmr_ovf)
    begin
      tmr_ovf_r <= 1'b0;
    end
  end

  assign o_tl      = tl_r;
  assign o_th      = th_r;
  assign o_tmr_ovf = tmr_ovf_r;
  assign o_tmr_irq = tmr_ovf_r && i_tmr_int_en; // RULE_12

  // ==========================================================
  // Overflow period in system clocks, for receive sampling
  logic [urt_pkg::PER_W-1:0] per_cnt_r;
  logic [urt_pkg::PER_W-1:0] per_r;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      per_cnt_r <= '0;
      per_r     <= '0;
    end
    else if (i_ce)
    begin
      per_cnt_r <= ovf_pulse ? '0 : per_cnt_r + 1'b1;
      if (ovf_pulse)
      begin
        per_r <= per_cnt_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Transmitter: one bit per two overflows
  logic        tx_busy_r;
  logic        tx_half_r;
  logic        txd_r;
  logic [3:0]  tx_left_r;
  logic [9:0]  tx_sr_r;
  logic        tx_done_r;
  logic        tx_end;

  assign tx_end = tx_busy_r && ovf_pulse && tx_half_r && (tx_left_r == 4'h1);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_busy_r <= 1'b0;
      tx_half_r <= 1'b0;
      txd_r     <= 1'b1;
      tx_left_r <= '0;
      tx_sr_r   <= '1;
    end
    else if (i_ce)
    begin
      if (!tx_busy_r && i_wr_stb)
      begin
        tx_busy_r <= 1'b1; // RULE_03
        tx_half_r <= 1'b0;
        txd_r     <= 1'b0; // RULE_16
        tx_left_r <= i_mode3 ? urt_pkg::FRAME_M3 : urt_pkg::FRAME_M1; // RULE_01
        tx_sr_r   <= {1'b1, i_mode3 ? i_wr_word.bit8 : 1'b1, i_wr_word.data};
      end
      else if (tx_busy_r && ovf_pulse)
      begin
        tx_half_r <= !tx_half_r; // RULE_17
        if (tx_half_r)
        begin
          if (tx_left_r == 4'h1)
          begin
            tx_busy_r <= 1'b0;
            txd_r     <= 1'b1;
          end
          else
          begin
            txd_r     <= tx_sr_r[0]; // RULE_16
            tx_sr_r   <= {1'b1, tx_sr_r[9:1]};
            tx_left_r <= tx_left_r - 4'h1;
          end
        end
      end
    end
  end

  assign o_txd = txd_r;

  // ==========================================================
  // Receiver
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_PUSH} urt_rx_st_t;
  urt_rx_st_t                rx_st_r;
  logic [urt_pkg::PER_W:0]   rx_cnt_r;
  logic [3:0]                rx_bits_r;
  logic [8:0]                rx_sr_r;
  urt_pkg::urt_word_t        rx_word_r;
  logic                      rx_zero;
  logic                      f_in_ready;
  logic                      f_out_valid;
  logic                      f_out_ready;
  urt_pkg::urt_word_t        f_out_data;
  logic                      rx_push;
  logic                      rx_done_r;

  assign rx_zero = (rx_cnt_r == '0);
  assign rx_push = i_ce && (rx_st_r == RX_PUSH) && f_in_ready;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_st_r   <= RX_IDLE;
      rx_cnt_r  <= '0;
      rx_bits_r <= '0;
      rx_sr_r   <= '0;
      rx_word_r <= '0;
    end
    else if (i_ce)
    begin
      rx_cnt_r <= rx_zero ? rx_cnt_r : rx_cnt_r - 1'b1;
      case (rx_st_r)
        RX_IDLE:
        begin
          if (i_rx_en && rxd_d_r && !rxd_s_r[1] && (per_r != '0))
          begin
            // Half a bit is one overflow period
            rx_st_r  <= RX_START;
            rx_cnt_r <= {1'b0, per_r}; // RULE_17
          end
        end
        RX_START:
        begin
          if (rx_zero)
          begin
            rx_st_r   <= rxd_s_r[1] ? RX_IDLE : RX_DATA;
            // One short: zero is seen a cycle after it is reached
            rx_cnt_r  <= {per_r, 1'b0} - 1'b1;
            rx_bits_r <= i_mode3 ? urt_pkg::DATA_M3 : urt_pkg::DATA_M1; // RULE_01
          end
        end
        RX_DATA:
        begin
          if (rx_zero)
          begin
            rx_sr_r   <= {rxd_s_r[1], rx_sr_r[8:1]}; // RULE_16
            rx_bits_r <= rx_bits_r - 4'h1;
            rx_cnt_r  <= {per_r, 1'b0} - 1'b1;
            if (rx_bits_r == 4'h1)
            begin
              rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_zero)
          begin
            // Framing error drops the byte
            rx_st_r   <= rxd_s_r[1] ? RX_PUSH : RX_IDLE; // RULE_16
            rx_word_r <= i_mode3 ? rx_sr_r : {1'b1, rx_sr_r[8:1]};
          end
        end
        RX_PUSH:
        begin
          // The word waits here for FIFO room; frames that arrive meanwhile are lost
          if (f_in_ready)
          begin
            rx_st_r <= RX_IDLE;
          end
        end
        default:
        begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  urt_fifo #(
    .W     (urt_pkg::FIFO_W),
    .DEPTH (urt_pkg::FIFO_DEPTH)
  ) urt_fifo_i (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_valid (rx_st_r == RX_PUSH), // RULE_02
    .o_ready (f_in_ready),
    .i_data  (rx_word_r),
    .o_valid (f_out_valid),
    .i_ready (f_out_ready),
    .o_data  (f_out_data)
  );

  // ==========================================================
  // Software-facing receive buffer
  urt_pkg::urt_word_t rd_word_r;
  logic               rd_full_r;

  assign f_out_ready = !rd_full_r || i_rd_stb;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rd_word_r <= '0;
      rd_full_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (f_out_valid && f_out_ready)
      begin
        rd_word_r <= f_out_data; // RULE_04
        rd_full_r <= 1'b1;
      end
      else if (i_rd_stb)
      begin
        rd_full_r <= 1'b0;
      end
    end
  end

  assign o_rd_word = rd_word_r; // RULE_04

  // ==========================================================
  // Completion flags: a set beats a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (tx_end)
      begin
        tx_done_r <= 1'b1; // RULE_05
      end
      else if (i_clr_tx_done)
      begin
        tx_done_r <= 1'b0; // RULE_06
      end
      if (rx_push)
      begin
        rx_done_r <= 1'b1; // RULE_05
      end
      else if (i_clr_rx_done)
      begin
        rx_done_r <= 1'b0; // RULE_06
      end
    end
  end

  assign o_tx_done = tx_done_r;
  assign o_rx_done = rx_done_r;
  assign o_ser_irq = i_ser_int_en && (tx_done_r || rx_done_r); // RULE_05

  // ==========================================================
  // Checks
  sequence s_tx_end;
    tx_end && i_ce;
  endsequence

  property p_tx_done;
    @(posedge i_clk) disable iff (i_reset)
    s_tx_end |=> tx_done_r && o_txd && !tx_busy_r;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx flag not set"); // RULE_05

  property p_flag_hold;
    @(posedge i_clk) disable iff (i_reset)
    tx_done_r && !i_clr_tx_done |=> tx_done_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("tx flag lost"); // RULE_06

  property p_rx_flag;
    @(posedge i_clk) disable iff (i_reset)
    rx_push |=> rx_done_r && f_out_valid;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("rx flag not set"); // RULE_02

  property p_idle_high;
    @(posedge i_clk) disable iff (i_reset)
    !tx_busy_r |-> o_txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high"); // RULE_16

  property p_reload;
    @(posedge i_clk) disable iff (i_reset)
    ovf_pulse && i_tmr_cfg.mode == urt_pkg::TM_RELOAD && !i_tl_wr && !i_th_wr
      |=> tl_r == $past(th_r) && th_r == $past(th_r) && tmr_ovf_r;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // RULE_11

  property p_wide;
    @(posedge i_clk) disable iff (i_reset)
    i_ce && tmr_tick && cnt_en && i_tmr_cfg.mode == urt_pkg::TM_16 && !i_th_wr &&
      !i_tl_wr && tl_r == urt_pkg::BYTE_ONES |=> th_r == $past(th_r) + 8'h01 && tl_r == 8'h00;
  endproperty
  a_wide: assert property (p_wide) else $error("16-bit carry wrong"); // RULE_10

  property p_stopped;
    @(posedge i_clk) disable iff (i_reset)
    !i_tmr_cfg.run && !i_tl_wr && !i_th_wr |=> $stable(tl_r) && $stable(th_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("timer ran while off"); // RULE_14

  property p_system_clock;
    @(posedge i_clk) disable iff (i_reset)
    i_ce && i_tmr_cfg.clk_sel && cnt_en && i_tmr_cfg.mode == urt_pkg::TM_RELOAD &&
      !i_tl_wr && tl_r != urt_pkg::BYTE_ONES |=> tl_r == $past(tl_r) + 8'h01;
  endproperty
  a_system_clock: assert property (p_system_clock) else $error("no count per clock"); // RULE_09

  property p_rd_buf;
    @(posedge i_clk) disable iff (i_reset)
    i_ce && f_out_valid && f_out_ready |=> o_rd_word == $past(f_out_data);
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("read buffer wrong"); // RULE_04
endmodule // urt_top

// [src/urt_pkg.sv]
// Overview of operation
// [RULE_01] The port is asynchronous and full duplex and offers only serial modes 1 and 3.
// [RULE_02] A completed receive byte is buffered so the next frame can arrive before it is read.
// [RULE_03] Each software write to serial_data_buffer loads the transmitter and starts a frame; the code ignores a write while a frame is being sent.
// [RULE_04] Each read of serial_data_buffer returns the receive buffer, never transmit data.
// [RULE_05] tx_done_flag and rx_done_flag are set on completion and raise the serial request.
// [RULE_06] Hardware never clears either flag on its own; software clears each one.
// [RULE_07] At 11.0592 MHz direct clock software loads 0xE8 for 230400 and 0xD0 for 115200 baud.
// [RULE_08] At 3.6864 MHz direct clock software loads 0xF0 for 115200 and 0x40 for 9600 baud.
// [RULE_09] Timer clock is system clock when timer_clk_sel is 1, else /12, /48 or external /8; the code also offers /4 (PS_DIV4).
// [RULE_10] Timer mode 1 counts like mode 0 but over the full 16 bits.
// [RULE_11] Timer mode 2 reloads the low byte from the high byte and sets the overflow flag.
// [RULE_12] The reload leaves the high byte unchanged; the flag requests an interrupt if enabled.
// [RULE_13] Software preloads the low byte before enabling the timer in mode 2.
// [RULE_14] The run bit enables counting when the gate bit is 0 or the external input is active.
// [RULE_15] The baud timer has its own count, reload, overflow flag and run control.
// [RULE_16] A frame is a low start bit, data LSB first, a ninth bit in mode 3, a high stop bit.
// [RULE_17] The serial bit rate is the baud timer overflow rate divided by two.
package urt_pkg;
  // ==========================================================
  // Sizes
  localparam int FIFO_W     = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int PER_W      = 24;
  // ==========================================================
  // Timer modes and prescaler selects
  localparam logic [1:0] TM_13     = 2'h0;
  localparam logic [1:0] TM_16     = 2'h1;
  localparam logic [1:0] TM_RELOAD = 2'h2;
  localparam logic [1:0] PS_DIV12  = 2'h0;
  localparam logic [1:0] PS_DIV4   = 2'h1;
  localparam logic [1:0] PS_DIV48  = 2'h2;
  localparam logic [1:0] PS_EXT8   = 2'h3;
  localparam logic [5:0] DIV12_LAST = 6'h0b;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [2:0] EXT8_LAST  = 3'h7;
  // ==========================================================
  // Counter values
  localparam logic [7:0] BYTE_ONES  = 8'hff;
  localparam logic [4:0] LOW5_ONES  = 5'h1f;
  localparam logic [7:0] TL_RESET   = 8'h00;
  localparam logic [7:0] TH_RESET   = 8'h00;
  // ==========================================================
  // Frame lengths in bits with start and stop, then data bit counts
  localparam logic [3:0] FRAME_M1   = 4'ha;
  localparam logic [3:0] FRAME_M3   = 4'hb;
  localparam logic [3:0] DATA_M1    = 4'h8;
  localparam logic [3:0] DATA_M3    = 4'h9;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] mode;
    logic       run;
    logic       gate;
    logic       int_pol;
    logic       clk_sel;
    logic [1:0] prescale;
  } urt_tmr_cfg_t;
  typedef struct packed {
    logic       bit8;
    logic [7:0] data;
  } urt_word_t;
endpackage

// [test/urt_partner.sv]
`timescale 1ns/100ps
// ==========================================================
// Remote serial transceiver
module urt_partner #(
  parameter int BIT_CYC = 32
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  initial o_rxd = 1'b1;
  // ==========================================================
  // Frame out: start, data LSB first, stop
  task automatic send(input logic [8:0] w, input int n);
    for (int i = 0; i < n + 2; i++)
    begin
      o_rxd <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : w[i-1];
      repeat (BIT_CYC) @(posedge i_clk);
    end
  endtask
  // ==========================================================
  // Frame in; start bit length is not aligned, so sample 1.25 bits in
  task automatic recv(input int n, output logic [8:0] w, output logic ok);
    int t;
    t = 0;
    w = 9'h000;
    while (i_txd !== 1'b0 && t < 4000)
    begin
      @(negedge i_clk);
      t++;
    end
    repeat (BIT_CYC / 4) @(negedge i_clk);
    ok = (t < 4000) && (i_txd === 1'b0);
    repeat (BIT_CYC) @(negedge i_clk);
    for (int i = 0; i <= n; i++)
    begin
      if (i < n)
        w[i] = i_txd;
      else
        ok = ok && (i_txd === 1'b1);
      repeat (BIT_CYC) @(negedge i_clk);
    end
  endtask
endmodule // urt_partner

// [test/urt_top_test.sv]
`timescale 1ns/100ps
// ==========================================================
// Bench
module urt_top_test;
  logic                  i_clk = 1'b0;
  logic                  i_reset = 1'b1;
  logic                  i_ext_clk = 1'b0;
  logic                  i_ext_int = 1'b0;
  logic                  i_mode3 = 1'b0;
  logic                  i_wr_stb = 1'b0;
  logic                  i_rd_stb = 1'b0;
  logic                  i_clr_tx_done = 1'b0;
  logic                  i_clr_rx_done = 1'b0;
  logic                  i_ser_int_en = 1'b0;
  logic                  i_tl_wr = 1'b0;
  logic                  i_th_wr = 1'b0;
  logic [7:0]            i_tmr_wdata = 8'h00;
  logic                  i_clr_tmr_ovf = 1'b0;
  logic                  i_tmr_int_en = 1'b0;
  urt_pkg::urt_word_t    i_wr_word = 9'h000;
  urt_pkg::urt_tmr_cfg_t cfg = 8'h00;
  urt_pkg::urt_word_t    o_rd_word;
  logic                  rxd;
  logic                  o_txd;
  logic                  o_tx_done;
  logic                  o_rx_done;
  logic                  o_ser_irq;
  logic                  o_tmr_ovf;
  logic                  o_tmr_irq;
  logic [7:0]            o_tl;
  logic [7:0]            o_th;
  int                    miscompares = 0;
  int                    comparisons = 0;
  int                    cycles = 0;
  always #4 i_clk = ~i_clk;
  // External timer clock, one rise every 4 system cycles
  always #16 i_ext_clk = ~i_ext_clk;
  urt_top urt_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_ext_clk(i_ext_clk),
    .i_ext_int(i_ext_int), .i_rxd(rxd), .o_txd(o_txd), .i_mode3(i_mode3), .i_rx_en(1'b1),
    .i_wr_stb(i_wr_stb), .i_wr_word(i_wr_word), .i_rd_stb(i_rd_stb), .o_rd_word(o_rd_word),
    .o_tx_done(o_tx_done), .o_rx_done(o_rx_done), .i_clr_tx_done(i_clr_tx_done),
    .i_clr_rx_done(i_clr_rx_done), .i_ser_int_en(i_ser_int_en), .o_ser_irq(o_ser_irq),
    .i_tmr_cfg(cfg), .i_tl_wr(i_tl_wr), .i_th_wr(i_th_wr), .i_tmr_wdata(i_tmr_wdata),
    .o_tl(o_tl), .o_th(o_th), .o_tmr_ovf(o_tmr_ovf), .i_clr_tmr_ovf(i_clr_tmr_ovf),
    .i_tmr_int_en(i_tmr_int_en), .o_tmr_irq(o_tmr_irq));
  urt_partner #(.BIT_CYC(32)) urt_partner_i (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));
  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic load(input logic [7:0] th, input logic [7:0] tl);
    i_th_wr = 1'b1;
    i_tmr_wdata = th;
    step(1);
    i_th_wr = 1'b0;
    i_tl_wr = 1'b1;
    i_tmr_wdata = tl;
    step(1);
    i_tl_wr = 1'b0;
  endtask
  task automatic write_tx(input logic [8:0] w);
    i_wr_word = w;
    i_wr_stb = 1'b1;
    step(1);
    i_wr_stb = 1'b0;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return o_tmr_ovf;
      1: return o_tx_done;
      2: return o_rx_done;
      default: return o_th[0];
    endcase
  endfunction
  task automatic wait_hi(input int k);
    int t;
    t = 0;
    while (pick(k) !== 1'b1 && t < 3000)
    begin
      step(1);
      t++;
    end
    check_bit(pick(k), 1'b1);
  endtask
  // ==========================================================
  // Timer scenarios
  task automatic t_reload();
    load(8'hfe, 8'hfe);
    i_tmr_int_en = 1'b1;
    cfg.mode = urt_pkg::TM_RELOAD;
    cfg.clk_sel = 1'b1;
    cfg.run = 1'b1;
    wait_hi(0);
    check_val({1'b0, o_tl}, 9'h0fe);
    check_val({1'b0, o_th}, 9'h0fe);
    check_bit(o_tmr_irq, 1'b1);
    step(1);
    check_val({1'b0, o_tl}, 9'h0ff);
    cfg.run = 1'b0;
    i_clr_tmr_ovf = 1'b1;
    step(1);
    i_clr_tmr_ovf = 1'b0;
    step(1);
    check_bit(o_tmr_irq, 1'b0);
    $display("test reload done");
  endtask
  task automatic t_gate_mode1();
    load(8'h00, 8'h10);
    cfg.gate = 1'b1;
    cfg.int_pol = 1'b1;
    cfg.run = 1'b1;
    step(10);
    check_val({1'b0, o_tl}, 9'h010);
    i_ext_int = 1'b1;
    step(10);
    check_bit(o_tl == 8'h10, 1'b0);
    cfg.run = 1'b0;
    cfg.gate = 1'b0;
    load(8'h00, 8'h3e);
    cfg.mode = urt_pkg::TM_13;
    cfg.run = 1'b1;
    step(2);
    cfg.run = 1'b0;
    check_val({o_th[0], o_tl}, 9'h100);
    load(8'h00, 8'hfe);
    cfg.mode = urt_pkg::TM_16;
    cfg.run = 1'b1;
    wait_hi(3);
    check_val({1'b0, o_tl}, 9'h000);
    cfg.run = 1'b0;
    $display("test gate and mode 1 done");
  endtask
  task automatic t_prescale();
    int div[4] = '{12, 48, 32, 4};
    logic [1:0] ps[4] = '{urt_pkg::PS_DIV12, urt_pkg::PS_DIV48, urt_pkg::PS_EXT8,
                          urt_pkg::PS_DIV4};
    logic [7:0] v;
    int n;
    cfg.mode = urt_pkg::TM_RELOAD;
    cfg.clk_sel = 1'b0;
    cfg.run = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      cfg.prescale = ps[k];
      step(120);
      // Two rounds: the first only finds a tick edge
      for (int r = 0; r < 2; r++)
      begin
        v = o_tl;
        n = 0;
        while (o_tl === v && n < 200)
        begin
          step(1);
          n++;
        end
      end
      check_val(n[8:0], div[k][8:0]);
    end
    $display("test prescale done");
  endtask
  task automatic t_baud();
    int n;
    i_clr_tmr_ovf = 1'b1;
    load(8'he8, 8'he8);
    i_clr_tmr_ovf = 1'b0;
    cfg.run = 1'b1;
    wait_hi(0);
    i_clr_tmr_ovf = 1'b1;
    step(1);
    i_clr_tmr_ovf = 1'b0;
    n = 1;
    while (o_tmr_ovf !== 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
    check_val(9'(2 * n), 9'h030);
    $display("test baud reload done");
  endtask
  // ==========================================================
  // Serial scenarios, bit time 2 overflows of 16 cycles
  task automatic t_tx();
    logic [8:0] w;
    logic ok;
    i_ser_int_en = 1'b1;
    fork
      urt_partner_i.recv(8, w, ok);
      begin
        write_tx(9'h05a);
        step(40);
        write_tx(9'h0ff);
      end
    join
    check_val(w, 9'h05a);
    check_bit(ok, 1'b1);
    wait_hi(1);
    check_bit(o_ser_irq, 1'b1);
    step(50);
    check_bit(o_tx_done, 1'b1);
    i_clr_tx_done = 1'b1;
    step(1);
    i_clr_tx_done = 1'b0;
    step(1);
    check_bit(o_ser_irq, 1'b0);
    $display("test transmit done");
  endtask
  task automatic t_duplex();
    logic [8:0] w;
    logic ok;
    i_mode3 = 1'b1;
    fork
      urt_partner_i.recv(9, w, ok);
      urt_partner_i.send(9'h1a5, 9);
      write_tx(9'h0c3);
    join
    check_val(w, 9'h0c3);
    check_bit(ok, 1'b1);
    wait_hi(2);
    step(2);
    check_val(o_rd_word, 9'h1a5);
    i_clr_rx_done = 1'b1;
    i_rd_stb = 1'b1;
    step(1);
    i_clr_rx_done = 1'b0;
    i_rd_stb = 1'b0;
    i_mode3 = 1'b0;
    step(1);
    check_bit(o_rx_done, 1'b0);
    $display("test full duplex done");
  endtask
  task automatic t_buffer();
    urt_partner_i.send(9'h011, 8);
    urt_partner_i.send(9'h022, 8);
    step(8);
    check_val(o_rd_word, 9'h111);
    i_rd_stb = 1'b1;
    step(1);
    i_rd_stb = 1'b0;
    step(3);
    check_val(o_rd_word, 9'h122);
    $display("test receive buffering done");
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    step(10);
    i_reset = 1'b0;
    check_bit(o_txd, 1'b1);
    check_bit(o_tx_done | o_rx_done | o_tmr_ovf, 1'b0);
    t_reload();
    t_gate_mode1();
    t_prescale();
    cfg.run = 1'b0;
    cfg.clk_sel = 1'b1;
    t_baud();
    load(8'hf0, 8'hf0);
    cfg.run = 1'b1;
    t_tx();
    t_duplex();
    t_buffer();
    finish_test();
  end
endmodule // urt_top_test
